/* include/nieb_defines.vh */
`ifndef NIEB_DEFINES_VH
`define NIEB_DEFINES_VH
// ****************************************
// page layout
// ****************************************
`define NIEB_COL_W          12
`define NIEB_COL_FIRST      12'h000
`define NIEB_SPARE_BASE     12'h800
`define NIEB_MARK_COL       12'h800
`define NIEB_CHK_BASE       12'h840
`define NIEB_PAGE_LAST      12'h87f
`define NIEB_PAGE_END       12'h880
`define NIEB_PAGE_BYTES     2176
`define NIEB_PROT_FIRST     4'h4
`define NIEB_MAIN_BYTES     10'h200
`define NIEB_MAIN_BIT       11
`define NIEB_SPARE_TOP      6'h20
// ****************************************
// check byte layout, 16 per sector
// ****************************************
`define NIEB_CHK_SYN_LO     4'h0
`define NIEB_CHK_SYN_HI     4'h1
`define NIEB_CHK_PAR        4'h2
`define NIEB_FILL_BYTE      8'hff
`define NIEB_SYN_W          13
`define NIEB_SYN_ZERO       13'h0000
`define NIEB_SYN_ONE        13'h0001
`define NIEB_SYN_MAX        13'h1060
`define NIEB_SECTORS        4
`define NIEB_SECT_LAST      2'h3
// ****************************************
// marker, status, feature
// ****************************************
`define NIEB_MARK_GOOD      8'hff
`define NIEB_ST_OK          2'h0
`define NIEB_ST_CORR        2'h1
`define NIEB_ST_FAIL        2'h2
`define NIEB_ECC_EN_RST     1'b1
`define NIEB_MIN_VALID      10'h1f6
`define NIEB_TOTAL_BLOCKS   10'h200
// ****************************************
// states
// ****************************************
`define NIEB_S_IDLE         3'h0
`define NIEB_S_PCALC        3'h1
`define NIEB_S_PFILL        3'h2
`define NIEB_S_PSEND        3'h3
`define NIEB_S_RLOAD        3'h4
`define NIEB_S_RFIX_RD      3'h5
`define NIEB_S_RFIX_WR      3'h6
`endif

/* design/nieb_syn_acc.v */
`timescale 1ns/10ps
`include "nieb_defines.vh"
module nieb_syn_acc (
   // clock and reset
   input  wire        clock,
   input  wire        nrst,
   // byte stream
   input  wire        clear,
   input  wire        en,
   input  wire [7:0]  data,
   input  wire [9:0]  koff,
   // running code
   output reg  [12:0] syn_reg,
   output reg         par_reg
);
   // ****************************************
   // per bit index terms
   // ****************************************
   wire [12:0] chain [0:8];
   assign chain[0] = `NIEB_SYN_ZERO;
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : bit_term
         localparam [12:0] OFF = g + 1;
         wire [12:0] idx = {koff, 3'h0} + OFF;
         assign chain[g+1] = chain[g] ^ (data[g] ? idx : `NIEB_SYN_ZERO);
      end
   endgenerate
   reg [12:0] syn_next;
   reg        par_next;
   always @* begin
      syn_next = syn_reg;
      par_next = par_reg;
      if (clear) begin
         syn_next = `NIEB_SYN_ZERO;
         par_next = 1'b0;
      end else if (en) begin
         syn_next = syn_reg ^ chain[8];
         par_next = par_reg ^ (^data);
      end
   end
   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         syn_reg <= `NIEB_SYN_ZERO;
         par_reg <= 1'b0;
      end else begin
         syn_reg <= syn_next;
         par_reg <= par_next;
      end
   end
endmodule

/* design/nieb_ecc_core.v */
// Function
// [RQ1] correction is enabled out of reset
// [RQ2] host changes correction via set-feature: one enables, zero disables
// [RQ3] program with correction computes check bytes over the cached 2k page first
// [RQ4] read loads cache from array, recomputes code and compares to stored
// [RQ5] detected error bits are repaired in the cache before data leaves
// [RQ6] with correction on, only corrected contents are returned to the host
// [RQ7] each corrected read updates a success or failure status
// [RQ8] main area 000h-7ffh is four separately covered 512-byte sectors
// [RQ9] spare group: two reserved, two unprotected, twelve protected bytes
// [RQ10] bytes 800h and 801h hold the bad-block marker, never covered
// [RQ11] check bytes live in 840h-87fh of each page
// [RQ12] with correction on, the check region takes no user data
// [RQ13] with correction off, the whole spare area is user data
// [RQ14] factory bad blocks carry non-ffh at column 2048 of pages 0 and 1
// [RQ15] host scans location 800h of pages 0 and 1 before use
// [RQ16] host avoids erasing blocks marked bad
// [RQ17] at least 502 of 512 blocks stay valid over life
// [RQ18] too many errors: leave data, report failure
// [RQ19] correction off: raw reads, programs without check bytes
`timescale 1ns/10ps
`include "nieb_defines.vh"
module nieb_ecc_core (
   // clock and reset
   input  wire        clock,
   input  wire        nrst,
   // feature control
   input  wire        feat_wr,
   input  wire        feat_ecc_en,
   output wire        ecc_en,
   // page commands
   input  wire        cmd_program,
   input  wire        cmd_read,
   output wire        busy,
   output reg         op_done_reg,
   // host cache port
   input  wire        host_wr,
   input  wire        host_rd,
   input  wire [11:0] host_col,
   input  wire [7:0]  host_wdata,
   output wire [7:0]  host_rdata,
   output reg         host_rvalid_reg,
   // array side
   input  wire        arr_rd_valid,
   input  wire [7:0]  arr_rd_data,
   output wire        arr_rd_ready,
   output reg         arr_wr_valid_reg,
   output wire [7:0]  arr_wr_data,
   // status
   output reg  [1:0]  ecc_status_reg,
   output reg         bad_mark_seen_reg,
   output wire [9:0]  min_valid_block_count
);
   // ****************************************
   // page layout helpers
   // ****************************************
   function covered;
      input [11:0] col;
      begin
         if (!col[`NIEB_MAIN_BIT])
            covered = 1'b1;
         else
            covered = (col[11:6] == `NIEB_SPARE_TOP) && (col[3:0] >= `NIEB_PROT_FIRST); // RQ9 RQ10
      end
   endfunction
   function [1:0] sect_of;
      input [11:0] col;
      begin
         sect_of = col[`NIEB_MAIN_BIT] ? col[5:4] : col[10:9]; // RQ8
      end
   endfunction
   function [9:0] koff_of;
      input [11:0] col;
      begin
         if (!col[`NIEB_MAIN_BIT])
            koff_of = {1'b0, col[8:0]};
         else
            koff_of = `NIEB_MAIN_BYTES + {6'h0, col[3:0] - `NIEB_PROT_FIRST};
      end
   endfunction
   // ****************************************
   // state and cache
   // ****************************************
   reg  [2:0]  state_reg;
   reg  [2:0]  state_next;
   reg  [11:0] col_reg;
   reg  [11:0] col_next;
   reg         ecc_en_reg;
   reg  [7:0]  cache_mem [0:`NIEB_PAGE_BYTES-1];
   reg  [7:0]  mem_q_reg;
   reg         pipe_v_reg;
   reg  [11:0] pipe_col_reg;
   reg  [1:0]  fix_sect_reg;
   reg  [11:0] fix_col_reg;
   reg  [2:0]  fix_bit_reg;
   reg  [1:0]  st_acc_reg;
   reg  [12:0] st_syn_reg [0:3];
   reg         st_par_reg [0:3];
   reg         st_blank_reg [0:3];
   wire        idle = (state_reg == `NIEB_S_IDLE);
   wire        in_page = (host_col <= `NIEB_PAGE_LAST);
   wire        chk_col = (host_col >= `NIEB_CHK_BASE) && in_page;
   wire        load_take = (state_reg == `NIEB_S_RLOAD) && arr_rd_valid;
   assign busy = !idle;
   assign ecc_en = ecc_en_reg;
   assign host_rdata = mem_q_reg;
   assign arr_wr_data = mem_q_reg;
   assign arr_rd_ready = (state_reg == `NIEB_S_RLOAD);
   assign min_valid_block_count = `NIEB_MIN_VALID; // RQ17
   // ****************************************
   // code accumulators, one per sector
   // ****************************************
   wire        acc_clear = idle && (cmd_program || cmd_read);
   wire [11:0] acc_col = load_take ? col_reg : pipe_col_reg;
   wire [7:0]  acc_data = load_take ? arr_rd_data : mem_q_reg;
   wire        acc_v = ecc_en_reg && covered(acc_col) && (load_take ||
                       (pipe_v_reg && state_reg == `NIEB_S_PCALC)); // RQ3 RQ4 RQ19
   wire [12:0] syn_w [0:3];
   wire        par_w [0:3];
   genvar s;
   generate
      for (s = 0; s < `NIEB_SECTORS; s = s + 1) begin : sect
         nieb_syn_acc u_acc (
            .clock   (clock),
            .nrst    (nrst),
            .clear   (acc_clear),
            .en      (acc_v && sect_of(acc_col) == s),
            .data    (acc_data),
            .koff    (koff_of(acc_col)),
            .syn_reg (syn_w[s]),
            .par_reg (par_w[s])
         );
      end
   endgenerate
   // ****************************************
   // check byte and decode
   // ****************************************
   reg  [7:0] chk_byte;
   always @* begin
      case (col_reg[3:0])
         `NIEB_CHK_SYN_LO: chk_byte = syn_w[col_reg[5:4]][7:0];
         `NIEB_CHK_SYN_HI: chk_byte = {3'h0, syn_w[col_reg[5:4]][12:8]};
         `NIEB_CHK_PAR:    chk_byte = {7'h0, par_w[col_reg[5:4]]};
         default:          chk_byte = `NIEB_FILL_BYTE;
      endcase
   end
   wire [12:0] d_syn = syn_w[fix_sect_reg] ^ st_syn_reg[fix_sect_reg];
   wire        d_par = par_w[fix_sect_reg] ^ st_par_reg[fix_sect_reg];
   wire [12:0] d_pos = d_syn - `NIEB_SYN_ONE;
   wire        d_zero = (d_syn == `NIEB_SYN_ZERO);
   wire        d_fix = d_par && !d_zero && (d_syn <= `NIEB_SYN_MAX) && !st_blank_reg[fix_sect_reg];
   // parity only catches odd counts; even multi-bit errors with a zero
   // syndrome can slip through, a known limit of this single-bit code
   wire        d_fail = !st_blank_reg[fix_sect_reg] &&
                        ((!d_par && !d_zero) || (d_par && d_syn > `NIEB_SYN_MAX)); // RQ18
   wire        d_corr = !st_blank_reg[fix_sect_reg] && d_par;
   wire [11:0] d_col = (d_pos[12:3] < `NIEB_MAIN_BYTES) ?
                       {1'b0, fix_sect_reg, d_pos[11:3]} :
                       (`NIEB_SPARE_BASE | {6'h0, fix_sect_reg, d_pos[6:3] + `NIEB_PROT_FIRST});
   wire [1:0]  st_worst = d_fail ? `NIEB_ST_FAIL :
                          (d_corr && st_acc_reg == `NIEB_ST_OK) ? `NIEB_ST_CORR : st_acc_reg;
   // ****************************************
   // cache ports
   // ****************************************
   reg        mem_we;
   reg [11:0] mem_wcol;
   reg [7:0]  mem_wdata;
   reg        mem_re;
   reg [11:0] mem_rcol;
   always @* begin
      mem_we = 1'b0;
      mem_wcol = col_reg;
      mem_wdata = arr_rd_data;
      mem_re = 1'b0;
      mem_rcol = col_reg;
      case (state_reg)
         `NIEB_S_IDLE: begin
            mem_we = host_wr && in_page && !(ecc_en_reg && chk_col); // RQ12 RQ13
            mem_wcol = host_col;
            mem_wdata = host_wdata;
            mem_re = host_rd && in_page; // RQ6
            mem_rcol = host_col;
         end
         `NIEB_S_PCALC: mem_re = (col_reg < `NIEB_CHK_BASE);
         `NIEB_S_PFILL: begin
            mem_we = 1'b1; // RQ11
            mem_wdata = chk_byte;
         end
         `NIEB_S_PSEND: mem_re = (col_reg <= `NIEB_PAGE_LAST);
         `NIEB_S_RLOAD: mem_we = arr_rd_valid;
         `NIEB_S_RFIX_RD: begin
            mem_re = d_fix;
            mem_rcol = d_col;
         end
         `NIEB_S_RFIX_WR: begin
            mem_we = 1'b1; // RQ5
            mem_wcol = fix_col_reg;
            mem_wdata = mem_q_reg ^ (8'h01 << fix_bit_reg);
         end
         default: mem_we = 1'b0;
      endcase
   end
   always @(posedge clock) begin
      if (mem_we)
         cache_mem[mem_wcol] <= mem_wdata;
   end
   always @(posedge clock or negedge nrst) begin
      if (!nrst)
         mem_q_reg <= 8'h00;
      else if (mem_re)
         mem_q_reg <= cache_mem[mem_rcol];
   end
   // ****************************************
   // sequencer
   // ****************************************
   always @* begin
      state_next = state_reg;
      col_next = col_reg;
      case (state_reg)
         `NIEB_S_IDLE: begin
            col_next = `NIEB_COL_FIRST;
            if (cmd_program)
               state_next = ecc_en_reg ? `NIEB_S_PCALC : `NIEB_S_PSEND; // RQ3 RQ19
            else if (cmd_read)
               state_next = `NIEB_S_RLOAD; // RQ4
         end
         `NIEB_S_PCALC: begin
            // one spare cycle drains the read pipe before codes are used
            if (col_reg == `NIEB_CHK_BASE)
               state_next = `NIEB_S_PFILL;
            else
               col_next = col_reg + 12'h001;
         end
         `NIEB_S_PFILL: begin
            col_next = col_reg + 12'h001;
            if (col_reg == `NIEB_PAGE_LAST) begin
               state_next = `NIEB_S_PSEND;
               col_next = `NIEB_COL_FIRST;
            end
         end
         `NIEB_S_PSEND: begin
            if (col_reg == `NIEB_PAGE_END)
               state_next = `NIEB_S_IDLE;
            else
               col_next = col_reg + 12'h001;
         end
         `NIEB_S_RLOAD: begin
            if (arr_rd_valid) begin
               col_next = col_reg + 12'h001;
               if (col_reg == `NIEB_PAGE_LAST)
                  state_next = ecc_en_reg ? `NIEB_S_RFIX_RD : `NIEB_S_IDLE; // RQ19
            end
         end
         `NIEB_S_RFIX_RD: begin
            if (d_fix)
               state_next = `NIEB_S_RFIX_WR;
            else if (fix_sect_reg == `NIEB_SECT_LAST)
               state_next = `NIEB_S_IDLE;
         end
         `NIEB_S_RFIX_WR:
            state_next = (fix_sect_reg == `NIEB_SECT_LAST) ? `NIEB_S_IDLE : `NIEB_S_RFIX_RD;
         default: state_next = `NIEB_S_IDLE;
      endcase
   end
   wire fix_last = (state_reg == `NIEB_S_RFIX_RD && !d_fix) || state_reg == `NIEB_S_RFIX_WR;
   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         state_reg <= `NIEB_S_IDLE;
         col_reg <= `NIEB_COL_FIRST;
         ecc_en_reg <= `NIEB_ECC_EN_RST; // RQ1
         pipe_v_reg <= 1'b0;
         pipe_col_reg <= `NIEB_COL_FIRST;
         fix_sect_reg <= 2'h0;
         fix_col_reg <= `NIEB_COL_FIRST;
         fix_bit_reg <= 3'h0;
         st_acc_reg <= `NIEB_ST_OK;
         ecc_status_reg <= `NIEB_ST_OK;
         bad_mark_seen_reg <= 1'b0;
         op_done_reg <= 1'b0;
         host_rvalid_reg <= 1'b0;
         arr_wr_valid_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         col_reg <= col_next;
         if (idle && feat_wr)
            ecc_en_reg <= feat_ecc_en; // RQ2
         pipe_v_reg <= mem_re && (state_reg == `NIEB_S_PCALC || state_reg == `NIEB_S_PSEND);
         pipe_col_reg <= col_reg;
         arr_wr_valid_reg <= mem_re && (state_reg == `NIEB_S_PSEND);
         host_rvalid_reg <= idle && host_rd && in_page;
         op_done_reg <= !idle && (state_next == `NIEB_S_IDLE);
         if (idle && cmd_read) begin
            fix_sect_reg <= 2'h0;
            st_acc_reg <= `NIEB_ST_OK;
            bad_mark_seen_reg <= 1'b0;
         end
         if (load_take && col_reg == `NIEB_MARK_COL)
            bad_mark_seen_reg <= (arr_rd_data != `NIEB_MARK_GOOD); // RQ14
         if (load_take && col_reg == `NIEB_PAGE_LAST && !ecc_en_reg)
            ecc_status_reg <= `NIEB_ST_OK;
         if (state_reg == `NIEB_S_RFIX_RD) begin
            st_acc_reg <= st_worst;
            fix_col_reg <= d_col;
            fix_bit_reg <= d_pos[2:0];
            if (!d_fix && fix_sect_reg == `NIEB_SECT_LAST)
               ecc_status_reg <= st_worst; // RQ7
         end
         if (state_reg == `NIEB_S_RFIX_WR && fix_sect_reg == `NIEB_SECT_LAST)
            ecc_status_reg <= st_acc_reg; // RQ7
         if (fix_last)
            fix_sect_reg <= fix_sect_reg + 2'h1;
      end
   end
   // ****************************************
   // stored check bytes from the array
   // ****************************************
   genvar t;
   generate
      for (t = 0; t < `NIEB_SECTORS; t = t + 1) begin : stored
         wire hit = load_take && (col_reg >= `NIEB_CHK_BASE) && (col_reg[5:4] == t);
         always @(posedge clock or negedge nrst) begin
            if (!nrst) begin
               st_syn_reg[t] <= `NIEB_SYN_ZERO;
               st_par_reg[t] <= 1'b0;
               st_blank_reg[t] <= 1'b0;
            end else if (hit) begin
               case (col_reg[3:0])
                  `NIEB_CHK_SYN_LO: st_syn_reg[t][7:0] <= arr_rd_data; // RQ11
                  `NIEB_CHK_SYN_HI: begin
                     st_syn_reg[t][12:8] <= arr_rd_data[4:0];
                     st_blank_reg[t] <= (arr_rd_data == `NIEB_FILL_BYTE);
                  end
                  `NIEB_CHK_PAR: begin
                     st_par_reg[t] <= arr_rd_data[0];
                     // erased sector: programmed parity byte is never all ones
                     st_blank_reg[t] <= st_blank_reg[t] && (arr_rd_data == `NIEB_FILL_BYTE);
                  end
                  default: st_par_reg[t] <= st_par_reg[t];
               endcase
            end
         end
      end
   endgenerate
endmodule

/* design/nieb_pad.v */
`timescale 1ns/10ps

/* sim/nieb_arr_model.sv */
`timescale 1ns/10ps
// ****************************************
// array model: stores pages, streams them back
// ****************************************
module nieb_arr_model (
   // clock and reset
   input  wire logic       clock,
   input  wire logic       nrst,
   // read stream
   input  wire logic       arr_rd_ready,
   output logic            arr_rd_valid,
   output logic [7:0]      arr_rd_data,
   // write stream
   input  wire logic       arr_wr_valid_reg,
   input  wire logic [7:0] arr_wr_data,
   // pacing
   input  wire logic       slow
);
   logic [7:0]  mem [0:2175];
   logic [11:0] rd_ptr_reg;
   logic [11:0] wr_ptr_reg;
   wire         take = arr_rd_valid && arr_rd_ready;
   wire  [11:0] nxt = rd_ptr_reg + {11'h000, take};
   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rd_ptr_reg <= 12'h000;
         wr_ptr_reg <= 12'h000;
         arr_rd_valid <= 1'b0;
         arr_rd_data <= 8'h00;
      end else begin
         // page lands in column order, no back-pressure
         if (arr_wr_valid_reg) begin
            mem[wr_ptr_reg] <= arr_wr_data;
            wr_ptr_reg <= (wr_ptr_reg == 12'h87f) ? 12'h000 : wr_ptr_reg + 12'h001;
         end
         rd_ptr_reg <= arr_rd_ready ? nxt : 12'h000;
         if (arr_rd_ready && nxt <= 12'h87f && !(slow && $urandom_range(1, 0))) begin
            arr_rd_valid <= 1'b1;
            arr_rd_data <= mem[nxt];
         end else begin
            // idle data line is junk: it inverts each idle cycle, so every second idle cycle shows the last byte again
            arr_rd_valid <= 1'b0;
            arr_rd_data <= ~arr_rd_data;
         end
      end
   end
endmodule

/* sim/nieb_ecc_core_chk.sv */
`timescale 1ns/10ps
// ****************************************
// checker
// ****************************************
module nieb_ecc_core_chk (
   // clock and reset
   input  wire logic        clock,
   input  wire logic        nrst,
   // feature and commands
   input  wire logic        feat_wr,
   input  wire logic        feat_ecc_en,
   input  wire logic        ecc_en,
   input  wire logic        cmd_program,
   input  wire logic        cmd_read,
   input  wire logic        busy,
   input  wire logic        op_done_reg,
   // host and array
   input  wire logic        host_rd,
   input  wire logic [11:0] host_col,
   input  wire logic        host_rvalid_reg,
   input  wire logic        arr_rd_ready,
   input  wire logic        arr_wr_valid_reg,
   // status
   input  wire logic [1:0]  ecc_status_reg,
   input  wire logic [9:0]  min_valid_block_count
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);
   logic [12:0] wait_cnt_reg;
   logic        prog_ecc_reg;
   // busy cycles before the first page byte leaves
   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         wait_cnt_reg <= 13'h0000;
         prog_ecc_reg <= 1'b0;
      end else if (cmd_program && !busy) begin
         wait_cnt_reg <= 13'h0000;
         prog_ecc_reg <= ecc_en;
      end else if (busy && !arr_wr_valid_reg && wait_cnt_reg != 13'h1fff) begin
         wait_cnt_reg <= wait_cnt_reg + 13'h0001;
      end
   end
   property p_en_hold; !$past(feat_wr) |-> $stable(ecc_en); endproperty
   a_en_hold: assert property (p_en_hold) else $error("ecc_en moved without write");
   property p_feat_set; feat_wr && !busy |=> ecc_en == $past(feat_ecc_en); endproperty
   a_feat_set: assert property (p_feat_set) else $error("ecc_en not written");
   property p_calc_first; $rose(arr_wr_valid_reg) && prog_ecc_reg |-> wait_cnt_reg >= 13'h0880;
   endproperty
   a_calc_first: assert property (p_calc_first) else $error("page sent before code");
   property p_rd_start; cmd_read && !cmd_program && !busy |=> busy && arr_rd_ready; endproperty
   a_rd_start: assert property (p_rd_start) else $error("read load not started");
   property p_ready_busy; arr_rd_ready |-> busy && !arr_wr_valid_reg; endproperty
   a_ready_busy: assert property (p_ready_busy) else $error("load outside read");
   property p_raw_prog; cmd_program && !busy && !ecc_en |-> ##2 arr_wr_valid_reg; endproperty
   a_raw_prog: assert property (p_raw_prog) else $error("raw program delayed");
   property p_rvalid; host_rd && !busy && host_col <= 12'h87f |=> host_rvalid_reg; endproperty
   a_rvalid: assert property (p_rvalid) else $error("cache read not answered");
   property p_rvalid_cause; host_rvalid_reg |-> $past(host_rd) && !$past(busy); endproperty
   a_rvalid_cause: assert property (p_rvalid_cause) else $error("data out while busy");
   property p_done; op_done_reg |-> !busy && $past(busy); endproperty
   a_done: assert property (p_done) else $error("done pulse misplaced");
   property p_status_when; $changed(ecc_status_reg) |-> op_done_reg || busy; endproperty
   a_status_when: assert property (p_status_when) else $error("status moved idle");
   property p_status_code; ecc_status_reg != 2'h3; endproperty
   a_status_code: assert property (p_status_code) else $error("bad status code");
   property p_nvb; min_valid_block_count == 10'h1f6; endproperty
   a_nvb: assert property (p_nvb) else $error("valid block count wrong");
   c_corr: cover property (op_done_reg && ecc_status_reg == 2'h1);
   c_fail: cover property (op_done_reg && ecc_status_reg == 2'h2);
   c_prog: cover property ($rose(arr_wr_valid_reg) && prog_ecc_reg);
endmodule
bind nieb_ecc_core nieb_ecc_core_chk u_chk (
   .clock(clock), .nrst(nrst), .feat_wr(feat_wr), .feat_ecc_en(feat_ecc_en),
   .ecc_en(ecc_en), .cmd_program(cmd_program), .cmd_read(cmd_read), .busy(busy),
   .op_done_reg(op_done_reg), .host_rd(host_rd), .host_col(host_col),
   .host_rvalid_reg(host_rvalid_reg), .arr_rd_ready(arr_rd_ready),
   .arr_wr_valid_reg(arr_wr_valid_reg), .ecc_status_reg(ecc_status_reg),
   .min_valid_block_count(min_valid_block_count)
);

/* sim/nand_internal_ecc_badblock_test.sv */
`timescale 1ns/10ps
`define CHK(n, e, a) chk(n, 16'(e), 16'(a))
// ****************************************
// bench
// ****************************************
module nand_internal_ecc_badblock_test;
   logic        clock, nrst, feat_wr, feat_ecc_en, cmd_program, cmd_read;
   logic        host_wr, host_rd, slow;
   logic [11:0] host_col;
   logic [7:0]  host_wdata;
   wire         ecc_en, busy, op_done_reg, host_rvalid_reg;
   wire         arr_rd_valid, arr_rd_ready, arr_wr_valid_reg, bad_mark_seen_reg;
   wire  [7:0]  host_rdata, arr_rd_data, arr_wr_data;
   wire  [1:0]  ecc_status_reg;
   wire  [9:0]  min_valid_block_count;
   int          miscompares, num_checks, c, s, b;
   logic [7:0]  exp_pg [0:2175];
   logic [15:0] exp_q [$];
   nieb_ecc_core u_dut (.clock(clock), .nrst(nrst), .feat_wr(feat_wr),
      .feat_ecc_en(feat_ecc_en), .ecc_en(ecc_en), .cmd_program(cmd_program),
      .cmd_read(cmd_read), .busy(busy), .op_done_reg(op_done_reg), .host_wr(host_wr),
      .host_rd(host_rd), .host_col(host_col), .host_wdata(host_wdata),
      .host_rdata(host_rdata), .host_rvalid_reg(host_rvalid_reg),
      .arr_rd_valid(arr_rd_valid), .arr_rd_data(arr_rd_data), .arr_rd_ready(arr_rd_ready),
      .arr_wr_valid_reg(arr_wr_valid_reg), .arr_wr_data(arr_wr_data),
      .ecc_status_reg(ecc_status_reg), .bad_mark_seen_reg(bad_mark_seen_reg),
      .min_valid_block_count(min_valid_block_count));
   nieb_arr_model u_arr (.clock(clock), .nrst(nrst), .arr_rd_ready(arr_rd_ready),
      .arr_rd_valid(arr_rd_valid), .arr_rd_data(arr_rd_data),
      .arr_wr_valid_reg(arr_wr_valid_reg), .arr_wr_data(arr_wr_data), .slow(slow));
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   task chk(input string n, input logic [15:0] e, input logic [15:0] a);
      num_checks++;
      if (a !== e) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", n, e, a);
      end
   endtask
   task print_verdict;
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // read results are paired with notes in issue order
   always @(posedge clock) begin
      if (host_rvalid_reg === 1'b1) begin
         if (exp_q.size() == 0) `CHK("stray cache read", 1, 0);
         else `CHK("cache byte", exp_q.pop_front(), host_rdata);
      end
   end
   task step;
      @(posedge clock);
      #1;
   endtask
   task hwr(input logic [11:0] cl, input logic [7:0] d);
      host_wr = 1'b1;
      host_col = cl;
      host_wdata = d;
      step;
   endtask
   task hrd(input logic [11:0] cl, input logic [7:0] e);
      host_rd = 1'b1;
      host_col = cl;
      exp_q.push_back({8'h00, e});
      step;
   endtask
   task run_cmd(input logic prog);
      int i;
      cmd_program = prog;
      cmd_read = !prog;
      step;
      cmd_program = 1'b0;
      cmd_read = 1'b0;
      for (i = 0; i < 20000 && op_done_reg !== 1'b1; i++) step;
      if (op_done_reg !== 1'b1) `CHK("op done", 1, 0);
   endtask
   task flip(input logic [11:0] cl, input logic [7:0] m);
      u_arr.mem[cl] = u_arr.mem[cl] ^ m;
   endtask
   // span: two programs, five reads
   initial begin
      #(40 * 60000);
      miscompares++;
      print_verdict;
   end
   initial begin
      {nrst, feat_wr, feat_ecc_en, cmd_program, cmd_read, host_wr, host_rd, slow} = 8'h00;
      host_col = 12'h000;
      host_wdata = 8'h00;
      void'($urandom(60));
      repeat (8) @(posedge clock);
      #1;
      nrst = 1'b1;
      step;
      `CHK("ecc_en at reset", 1, ecc_en);
      `CHK("valid blocks", 10'h1f6, min_valid_block_count);
      for (c = 0; c < 12'h840; c++) begin
         exp_pg[c] = (c == 12'h800) ? 8'hff : 8'($urandom);
         hwr(12'(c), exp_pg[c]);
      end
      host_wr = 1'b0;
      run_cmd(1'b1);
      for (c = 0; c < 12'h840; c++) `CHK("array byte", exp_pg[c], u_arr.mem[c]);
      for (s = 0; s < 4; s++)
         for (b = 3; b < 16; b++) `CHK("check fill", 8'hff, u_arr.mem[12'h840 + 16 * s + b]);
      // one bit each in main, protected spare, unprotected spare; marker set
      c = $urandom_range(12'h1ff, 0);
      flip(12'(c), 8'h10);
      flip(12'h816, 8'h01);
      flip(12'h812, 8'h80);
      flip(12'h800, 8'hff);
      slow = 1'b1;
      run_cmd(1'b0);
      `CHK("status corrected", 2'h1, ecc_status_reg);
      `CHK("bad mark seen", 1, bad_mark_seen_reg);
      hrd(12'(c), exp_pg[c]);
      hrd(12'h816, exp_pg[12'h816]);
      hrd(12'h812, exp_pg[12'h812] ^ 8'h80);
      hrd(12'h800, 8'h00);
      host_rd = 1'b0;
      // reserved check byte refuses host data while correcting
      hwr(12'h843, 8'h00);
      host_wr = 1'b0;
      hrd(12'h843, 8'hff);
      host_rd = 1'b0;
      // two bits in one sector: beyond repair, data left alone
      flip(12'h450, 8'h01);
      flip(12'h451, 8'h02);
      flip(12'h800, 8'hff);
      run_cmd(1'b0);
      `CHK("status failed", 2'h2, ecc_status_reg);
      `CHK("bad mark clear", 0, bad_mark_seen_reg);
      hrd(12'h451, exp_pg[12'h451] ^ 8'h02);
      host_rd = 1'b0;
      flip(12'(c), 8'h10);
      flip(12'h816, 8'h01);
      flip(12'h450, 8'h01);
      flip(12'h451, 8'h02);
      run_cmd(1'b0);
      `CHK("status clean", 2'h0, ecc_status_reg);
      slow = 1'b0;
      feat_ecc_en = 1'b0;
      feat_wr = 1'b1;
      step;
      feat_wr = 1'b0;
      `CHK("ecc_en off", 0, ecc_en);
      hwr(12'h840, 8'h5a);
      hwr(12'h87f, 8'ha5);
      hwr(12'h841, 8'hff);
      hwr(12'h842, 8'hff);
      host_wr = 1'b0;
      run_cmd(1'b1);
      `CHK("spare user 840", 8'h5a, u_arr.mem[12'h840]);
      `CHK("spare user 87f", 8'ha5, u_arr.mem[12'h87f]);
      `CHK("raw program", exp_pg[12'h123], u_arr.mem[12'h123]);
      flip(12'h010, 8'h04);
      run_cmd(1'b0);
      `CHK("status raw", 2'h0, ecc_status_reg);
      hrd(12'h010, exp_pg[12'h010] ^ 8'h04);
      hrd(12'h840, 8'h5a);
      host_rd = 1'b0;
      feat_ecc_en = 1'b1;
      feat_wr = 1'b1;
      step;
      feat_wr = 1'b0;
      `CHK("ecc_en on", 1, ecc_en);
      run_cmd(1'b0);
      `CHK("erased", 2'h0, ecc_status_reg);
      hrd(12'h010, exp_pg[12'h010] ^ 8'h04);
      host_rd = 1'b0;
      step;
      `CHK("reads drained", 0, exp_q.size());
      print_verdict;
   end
endmodule
